/* File: logic/cfs_core.sv */
// Instruction sequencing core: four-phase cycle, prefetch pipeline, program
// counter, two-level return stack, interrupt deferral and the accumulator ALU.
// Assumes program and data memory answer one clock after a registered request
// and that all inputs are synchronous to clk.
`timescale 1ns/10ps
`include "cfs_defs.svh"

// What this block does
// RL1: Four non-overlapping phases form one instruction cycle.
// RL2: Fetch and advance counter at first phase.
// RL3: Fetch next while executing current instruction.
// RL4: Branches take two cycles: target, then branch.
// RL5: Counter steps by one unless transferring elsewhere.
// RL6: Counter is ten bits: two high, eight low.
// RL7: Low byte readable, writable; jumps within page.
// RL8: Low byte write inserts one dummy cycle.
// RL9: Jumps, calls, interrupts, reset load counter directly.
// RL10: Met skip discards prefetch, runs dummy cycle.
// RL11: Two-level stack, counter values, software-invisible.
// RL12: Call/interrupt push; returns restore from stack.
// RL13: Reset points stack pointer at top.
// RL14: Full stack defers interrupt until return.
// RL15: Call on full stack overflows, oldest lost.
// RL16: Operands and results move through accumulator, ALU.
// RL17: Result to chosen register, status flags updated.
// RL18: Add, subtract, with carry, decimal adjust.
// RL19: AND, OR, XOR, complement to either destination.
// RL20: Rotations, increment, decrement to either destination.
// RL21: Reset starts execution at address zero.
// RL22: Rotate through carry swaps end bit, carry.
module cfs_core (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic [13:0]     pm_data,
  input  wire logic [7:0]      dm_rdata,
  input  wire logic            irq_event,
  output cfs_pkg::cfs_pm_req_s pm_req,
  output cfs_pkg::cfs_dm_req_s dm_req,
  output logic [3:0]           instr_phase_clocks,
  output logic                 irq_ack,
  input  wire logic [4:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  output logic [31:0]          avs_readdata,
  output logic                 avs_waitrequest
);

  cfs_pkg::cfs_state_s s_r;
  cfs_pkg::cfs_state_s s_nxt;

  logic [1:0]          cls;
  logic [2:0]          msub;
  logic                is_alu;
  logic                pcl_addr;
  logic                mem_rd;
  logic [7:0]          alu_res;
  cfs_pkg::cfs_flags_s alu_flags;

  ////////////////////////////////////////////////////////////////////////////

  assign cls      = s_r.ir[`CFS_F_CLS];
  assign msub     = s_r.ir[`CFS_F_MSUB];
  assign is_alu   = (cls == `CFS_CLS_MEM) || (cls == `CFS_CLS_LIT);
  assign pcl_addr = (s_r.ir[`CFS_F_ADDR] == `CFS_PCL_DADDR);
  assign mem_rd   = !s_r.ir_dummy && !s_r.ir_int &&
                    ((cls == `CFS_CLS_MEM) ||
                     (cls == `CFS_CLS_MISC && (msub == `CFS_MS_SZ || msub == `CFS_MS_SNZ)));

  cfs_alu u_alu (
    .func (cfs_pkg::cfs_alu_e'(s_r.ir[`CFS_F_FUNC])),
    .acc  (s_r.acc),
    .opnd (s_r.opnd),
    .fin  (s_r.flags),
    .res  (alu_res),
    .fout (alu_flags)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin : comb_next
    logic       redir;
    logic       push;
    logic       pop;
    logic       wr_res;
    logic [9:0] tgt;
    logic [9:0] push_val;
    logic [7:0] wval;
    redir    = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    wr_res   = 1'b0;
    tgt      = s_r.pc;
    push_val = s_r.ir_addr;
    wval     = alu_res;
    s_nxt    = s_r;
    s_nxt.irq_ack = 1'b0;
    s_nxt.dm.wr   = 1'b0;

    case (s_r.phase)
      cfs_pkg::ph_t1: begin
        // The counter always points one word past the fetch in flight.
        s_nxt.pm.addr = s_r.pc; // RL2
        s_nxt.pm.rd   = 1'b1;
        s_nxt.pc      = s_r.pc + 10'h001; // RL5
        s_nxt.phase   = cfs_pkg::ph_t2; // RL1
      end
      cfs_pkg::ph_t2: begin
        s_nxt.pm.rd   = 1'b0;
        s_nxt.dm.addr = s_r.ir[`CFS_F_ADDR];
        s_nxt.dm.rd   = mem_rd && !pcl_addr;
        s_nxt.phase   = cfs_pkg::ph_t3; // RL1
      end
      cfs_pkg::ph_t3: begin
        s_nxt.dm.rd = 1'b0;
        if (cls == `CFS_CLS_LIT) begin
          s_nxt.opnd = s_r.ir[`CFS_F_LIT];
        end else if (pcl_addr) begin
          s_nxt.opnd = s_r.ir_addr[7:0]; // RL7
        end else begin
          s_nxt.opnd = dm_rdata; // RL16
        end
        s_nxt.phase = cfs_pkg::ph_t4; // RL1
      end
      cfs_pkg::ph_t4: begin
        s_nxt.phase = cfs_pkg::ph_t1; // RL1
        if (s_r.ir_int) begin
          // Acknowledged interrupt: saves the address of the replaced word.
          push     = 1'b1; // RL12
          push_val = s_r.ir_addr;
          redir    = 1'b1;
          tgt      = `CFS_INT_VEC; // RL9
        end else if (!s_r.ir_dummy) begin
          if (is_alu) begin
            s_nxt.flags = alu_flags; // RL17
            if (cls == `CFS_CLS_MEM && s_r.ir[`CFS_F_DEST]) begin
              wr_res = 1'b1; // RL17
            end else begin
              s_nxt.acc = alu_res; // RL16
            end
          end else if (cls == `CFS_CLS_BR) begin
            push     = s_r.ir[`CFS_F_CALL]; // RL12
            push_val = s_r.ir_addr + 10'h001;
            redir    = 1'b1; // RL4
            tgt      = s_r.ir[`CFS_F_TGT]; // RL9
          end else begin
            case (msub)
              `CFS_MS_RET:  pop = 1'b1; // RL12
              `CFS_MS_INTERRUPT_RETURN: begin
                pop          = 1'b1; // RL12
                s_nxt.int_en = 1'b1;
              end
              // A met skip refetches at the counter, dropping the prefetch.
              `CFS_MS_SZ:   redir = (s_r.opnd == 8'h00); // RL10
              `CFS_MS_SNZ:  redir = (s_r.opnd != 8'h00); // RL10
              `CFS_MS_MOVM: begin
                wr_res = 1'b1;
                wval   = s_r.acc;
              end
              default: ;
            endcase
          end
        end

        if (wr_res) begin
          if (pcl_addr) begin
            redir = 1'b1; // RL8
            tgt   = {s_r.ir_addr[9:8], wval}; // RL7
          end else begin
            s_nxt.dm.wr    = 1'b1;
            s_nxt.dm.wdata = wval;
          end
        end

        // Stack: the pointer counts saved entries, zero is the top.
        if (push) begin
          if (s_r.sp == `CFS_STK_FULL) begin
            s_nxt.stk[0] = s_r.stk[1]; // RL15
            s_nxt.stk[1] = push_val; // RL15
          end else begin
            s_nxt.stk[s_r.sp[0]] = push_val; // RL11
            s_nxt.sp             = s_r.sp + 2'h1;
          end
        end
        if (pop) begin
          redir = 1'b1;
          if (s_r.sp != 2'h0) begin
            tgt      = s_r.stk[s_r.sp[1]]; // RL12
            s_nxt.sp = s_r.sp - 2'h1;
          end else begin
            tgt = s_r.stk[0];
          end
        end

        // A bus write of the low byte jumps within the executing page.
        if (s_r.pcl_pend) begin
          redir          = 1'b1; // RL8
          tgt            = {s_r.ir_addr[9:8], s_r.pcl_val}; // RL7
          s_nxt.pcl_pend = 1'b0;
        end

        if (redir) begin
          s_nxt.pc       = tgt; // RL9
          s_nxt.ir_dummy = 1'b1; // RL4
          s_nxt.ir_int   = 1'b0;
        end else begin
          s_nxt.ir       = pm_data; // RL3
          s_nxt.ir_addr  = s_r.pm.addr;
          s_nxt.ir_dummy = 1'b0;
          s_nxt.ir_int   = 1'b0;
          // Acknowledge only with room on the stack, so a return frees it.
          if (s_r.irq_flag && s_r.int_en && s_nxt.sp != `CFS_STK_FULL) begin
            s_nxt.ir_int   = 1'b1; // RL14
            s_nxt.irq_flag = 1'b0;
            s_nxt.int_en   = 1'b0;
            s_nxt.irq_ack  = 1'b1;
          end
        end
      end
      default: s_nxt.phase = cfs_pkg::ph_t1;
    endcase

    // A new request wins over the acknowledge that clears the flag.
    if (irq_event) begin
      s_nxt.irq_flag = 1'b1; // RL14
    end

    case (s_nxt.phase)
      cfs_pkg::ph_t1: s_nxt.phase_clk = 4'h1; // RL1
      cfs_pkg::ph_t2: s_nxt.phase_clk = 4'h2;
      cfs_pkg::ph_t3: s_nxt.phase_clk = 4'h4;
      cfs_pkg::ph_t4: s_nxt.phase_clk = 4'h8;
      default:        s_nxt.phase_clk = 4'h0;
    endcase

    // Avalon slave: answer in the cycle after the request, act on the edge
    // at which the master sees waitrequest low.
    s_nxt.waitreq = 1'b1;
    if ((avs_read || avs_write) && s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      case (avs_address)
        `CFS_REG_PCL:    s_nxt.rdata = {24'h000000, s_r.ir_addr[7:0]}; // RL7
        `CFS_REG_CTRL:   s_nxt.rdata = {31'h00000000, s_r.int_en};
        `CFS_REG_STATUS: s_nxt.rdata = {25'h0000000, s_r.irq_flag, s_r.sp, s_r.flags};
        `CFS_REG_ACC:    s_nxt.rdata = {24'h000000, s_r.acc};
        `CFS_REG_PC:     s_nxt.rdata = {22'h000000, s_r.ir_addr}; // RL6
        default:         s_nxt.rdata = 32'h00000000;
      endcase
    end else if (avs_write && !s_r.waitreq) begin
      case (avs_address)
        `CFS_REG_PCL: begin
          s_nxt.pcl_pend = 1'b1; // RL7
          s_nxt.pcl_val  = avs_writedata[7:0];
        end
        `CFS_REG_CTRL: s_nxt.int_en = avs_writedata[`CFS_CTRL_INTEN];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r           <= '0;
      s_r.phase     <= cfs_pkg::ph_t1;
      s_r.phase_clk <= 4'h0;
      s_r.pc        <= `CFS_RST_VEC; // RL21
      s_r.ir_dummy  <= 1'b1;
      s_r.sp        <= 2'h0; // RL13
      s_r.int_en    <= `CFS_CTRL_RST;
      s_r.waitreq   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pm_req             = s_r.pm;
  assign dm_req             = s_r.dm;
  assign instr_phase_clocks = s_r.phase_clk;
  assign irq_ack            = s_r.irq_ack;
  assign avs_readdata       = s_r.rdata;
  assign avs_waitrequest    = s_r.waitreq;

endmodule // cfs_core

/* File: shared/cfs_defs.svh */
// Offsets, field positions, reset values and encodings of the sequencing core.
// Assumes inclusion by bare name from the package and design files.
`ifndef CFS_DEFS_SVH
`define CFS_DEFS_SVH

// Avalon-MM byte offsets.
`define CFS_REG_PCL      5'h00
`define CFS_REG_CTRL     5'h04
`define CFS_REG_STATUS   5'h08
`define CFS_REG_ACC      5'h0c
`define CFS_REG_PC       5'h10

// Control and status bit positions.
`define CFS_CTRL_INTEN   0
`define CFS_CTRL_RST     1'h0
`define CFS_ST_C         0
`define CFS_ST_AC        1
`define CFS_ST_Z         2
`define CFS_ST_OV        3
`define CFS_ST_SP        5:4
`define CFS_ST_IRQ       6

// Instruction fields of the 14-bit word.
`define CFS_F_CLS        13:12
`define CFS_F_FUNC       11:8
`define CFS_F_DEST       7
`define CFS_F_ADDR       6:0
`define CFS_F_LIT        7:0
`define CFS_F_CALL       11
`define CFS_F_TGT        9:0
`define CFS_F_MSUB       11:9

// Instruction classes and miscellaneous sub-codes.
`define CFS_CLS_MEM      2'h0
`define CFS_CLS_LIT      2'h1
`define CFS_CLS_BR       2'h2
`define CFS_CLS_MISC     2'h3
`define CFS_MS_RET       3'h0
`define CFS_MS_INTERRUPT_RETURN      3'h1
`define CFS_MS_SZ        3'h2
`define CFS_MS_SNZ       3'h3
`define CFS_MS_MOVM      3'h4

// Vectors, data address of the low program counter byte, stack size.
`define CFS_RST_VEC      10'h000
`define CFS_INT_VEC      10'h004
`define CFS_PCL_DADDR    7'h02
`define CFS_STK_FULL     2'h2

`endif

/* File: shared/cfs_pkg.sv */
// Types shared by the sequencing core and its ALU.
// Assumes nothing beyond the constants header.
`include "cfs_defs.svh"

package cfs_pkg;

  typedef enum logic [1:0] {ph_t1, ph_t2, ph_t3, ph_t4} cfs_phase_e;

  typedef enum logic [3:0] {
    alu_add, alu_adc, alu_sub, alu_sbc, alu_and, alu_or, alu_xor, alu_cpl,
    alu_daa, alu_rr, alu_rrc, alu_rl, alu_rlc, alu_inc, alu_dec, alu_mov
  } cfs_alu_e;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } cfs_flags_s;

  typedef struct packed {
    logic [9:0] addr;
    logic       rd;
  } cfs_pm_req_s;

  typedef struct packed {
    logic [6:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } cfs_dm_req_s;

  typedef struct packed {
    cfs_phase_e       phase;
    logic [3:0]       phase_clk;
    logic [9:0]       pc;
    cfs_pm_req_s      pm;
    cfs_dm_req_s      dm;
    logic [13:0]      ir;
    logic [9:0]       ir_addr;
    logic             ir_dummy;
    logic             ir_int;
    logic [7:0]       opnd;
    logic [7:0]       acc;
    cfs_flags_s       flags;
    logic [1:0][9:0]  stk;
    logic [1:0]       sp;
    logic             irq_flag;
    logic             int_en;
    logic             irq_ack;
    logic             pcl_pend;
    logic [7:0]       pcl_val;
    logic             waitreq;
    logic [31:0]      rdata;
  } cfs_state_s;

endpackage

/* File: logic/cfs_alu.sv */
// Eight-bit accumulator ALU: arithmetic, logic, rotation, increment, decrement.
// Assumes the caller registers its result and flags; purely combinational.
`timescale 1ns/10ps

module cfs_alu (
  input  cfs_pkg::cfs_alu_e   func,
  input  wire logic [7:0]     acc,
  input  wire logic [7:0]     opnd,
  input  cfs_pkg::cfs_flags_s fin,
  output logic [7:0]          res,
  output cfs_pkg::cfs_flags_s fout
);

  logic [8:0] sum9;
  logic [4:0] half5;
  logic [7:0] bsel;
  logic       cin;
  logic       hi_adj;

  always_comb begin
    sum9   = 9'h000;
    half5  = 5'h00;
    bsel   = opnd;
    cin    = 1'b0;
    hi_adj = 1'b0;
    fout   = fin;
    res    = opnd;
    case (func)
      cfs_pkg::alu_add, cfs_pkg::alu_adc, cfs_pkg::alu_sub, cfs_pkg::alu_sbc: begin
        // Subtraction adds the complement, so carry set means no borrow.
        bsel    = (func == cfs_pkg::alu_sub || func == cfs_pkg::alu_sbc) ? ~opnd : opnd;
        cin     = (func == cfs_pkg::alu_sub) ? 1'b1 :
                  (func == cfs_pkg::alu_add) ? 1'b0 : fin.c;
        sum9    = {1'b0, acc} + {1'b0, bsel} + {8'h00, cin}; // RL18
        half5   = {1'b0, acc[3:0]} + {1'b0, bsel[3:0]} + {4'h0, cin};
        res     = sum9[7:0];
        fout.c  = sum9[8]; // RL17
        fout.ac = half5[4];
        fout.ov = (acc[7] == bsel[7]) && (sum9[7] != acc[7]);
        fout.z  = (sum9[7:0] == 8'h00);
      end
      cfs_pkg::alu_and: begin
        res    = acc & opnd; // RL19
        fout.z = ((acc & opnd) == 8'h00);
      end
      cfs_pkg::alu_or: begin
        res    = acc | opnd; // RL19
        fout.z = ((acc | opnd) == 8'h00);
      end
      cfs_pkg::alu_xor: begin
        res    = acc ^ opnd; // RL19
        fout.z = ((acc ^ opnd) == 8'h00);
      end
      cfs_pkg::alu_cpl: begin
        res    = ~opnd; // RL19
        fout.z = (opnd == 8'hff);
      end
      cfs_pkg::alu_daa: begin
        sum9   = {1'b0, acc} + ((acc[3:0] > 4'h9 || fin.ac) ? 9'h006 : 9'h000); // RL18
        hi_adj = (sum9[7:4] > 4'h9) || fin.c || sum9[8];
        sum9   = sum9 + (hi_adj ? 9'h060 : 9'h000);
        res    = sum9[7:0];
        fout.c = hi_adj;
      end
      cfs_pkg::alu_rr:  res = {opnd[0], opnd[7:1]}; // RL20
      cfs_pkg::alu_rl:  res = {opnd[6:0], opnd[7]}; // RL20
      cfs_pkg::alu_rrc: begin
        res    = {fin.c, opnd[7:1]}; // RL22
        fout.c = opnd[0];
      end
      cfs_pkg::alu_rlc: begin
        res    = {opnd[6:0], fin.c}; // RL22
        fout.c = opnd[7];
      end
      cfs_pkg::alu_inc: begin
        res    = opnd + 8'h01; // RL20
        fout.z = (opnd == 8'hff);
      end
      cfs_pkg::alu_dec: begin
        res    = opnd - 8'h01; // RL20
        fout.z = (opnd == 8'h01);
      end
      default: res = opnd;
    endcase
  end

endmodule // cfs_alu

/* File: verif/cfs_core_asserts.sv */
// Concurrent checks on the ports of the sequencing core.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/10ps
module cfs_core_asserts (
  input wire logic            clk,
  input wire logic            sys_rst,
  input cfs_pkg::cfs_pm_req_s pm_req,
  input cfs_pkg::cfs_dm_req_s dm_req,
  input wire logic [3:0]      instr_phase_clocks,
  input wire logic            irq_ack,
  input wire logic            avs_read,
  input wire logic            avs_write,
  input wire logic            avs_waitrequest
);
  logic [3:0] ph_rot;
  assign ph_rot = {instr_phase_clocks[2:0], instr_phase_clocks[3]};
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////////////////
  // The first cycle after release still shows the all-zero reset value.
  a_phase_onehot: assert property (!$past(sys_rst) |-> $onehot(instr_phase_clocks))
    else $error("phase clocks not one-hot");
  a_phase_step: assert property ((instr_phase_clocks != 4'h0) |=>
    instr_phase_clocks == $past(ph_rot)) else $error("phase order broken");
  a_fetch_t2: assert property (pm_req.rd |-> instr_phase_clocks == 4'h2)
    else $error("fetch outside second phase");
  a_fetch_each: assert property (pm_req.rd |=> !pm_req.rd [*3] ##1 pm_req.rd)
    else $error("fetch not once per instruction cycle");
  a_rst_vector: assert property ($fell(sys_rst) |=> pm_req.rd && pm_req.addr == 10'h000)
    else $error("first fetch not at address zero");
  a_dm_rd_t3: assert property (dm_req.rd |-> instr_phase_clocks == 4'h4)
    else $error("operand read outside third phase");
  a_dm_wr_t1: assert property (dm_req.wr |-> instr_phase_clocks == 4'h1)
    else $error("result write outside first phase");
  a_ack_vector: assert property (irq_ack |-> ##[1:12] (pm_req.rd && pm_req.addr == 10'h004))
    else $error("no fetch from interrupt vector");
  a_ack_pulse: assert property (irq_ack |-> instr_phase_clocks == 4'h1 ##1 !irq_ack [*3])
    else $error("acknowledge not a single pulse");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing wrong");
  c_ack: cover property (irq_ack);
  c_dm_write: cover property (dm_req.wr);
  c_bus_write: cover property (avs_write && !avs_waitrequest);
endmodule // cfs_core_asserts

bind cfs_core cfs_core_asserts i_cfs_chk (.clk(clk), .sys_rst(sys_rst), .pm_req(pm_req),
  .dm_req(dm_req), .instr_phase_clocks(instr_phase_clocks), .irq_ack(irq_ack),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

/* File: verif/cfs_mem_model.sv */
// Program and data memory facing the sequencing core.
// Assumes the bench fills the arrays by hierarchical access before reset release.
`timescale 1ns/10ps
module cfs_mem_model (
  input wire logic            clk,
  input cfs_pkg::cfs_pm_req_s pm_req,
  input cfs_pkg::cfs_dm_req_s dm_req,
  input wire logic [3:0]      instr_phase_clocks,
  output logic [13:0]         pm_data,
  output logic [7:0]          dm_rdata
);
  logic [13:0] pm_mem [0:1023];
  logic [7:0]  dm_mem [0:127];
  logic        pm_valid;
  logic        junk;
  initial begin
    pm_valid = 1'b0;
    junk = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // The word is only promised from the cycle after the fetch pulse to the end of the fourth
  // phase; outside that a toggling pattern hides any late sampling.
  always @(posedge clk) begin
    junk <= ~junk;
    if (pm_req.rd)
      pm_valid <= 1'b1;
    else if (instr_phase_clocks[3])
      pm_valid <= 1'b0;
    if (dm_req.wr)
      dm_mem[dm_req.addr] <= dm_req.wdata;
  end
  assign pm_data  = pm_valid ? pm_mem[pm_req.addr] : {7{junk, ~junk}};
  assign dm_rdata = dm_req.rd ? dm_mem[dm_req.addr] : {4{junk, ~junk}};
  task automatic wipe;
    for (int i = 0; i < 1024; i++) pm_mem[i] = 14'h3e00;
    for (int i = 0; i < 128; i++) dm_mem[i] = 8'h00;
  endtask
endmodule // cfs_mem_model

/* File: verif/testbench.sv */
// Self-checking bench for the sequencing core with its memory model.
// Assumes the package and the core are compiled first.
`timescale 1ns/10ps
module testbench;
  logic                 clk, sys_rst, irq_event, irq_ack, avs_read, avs_write;
  logic                 avs_waitrequest, hit, acked, old_seen;
  logic [4:0]           avs_address;
  logic [31:0]          avs_writedata, avs_readdata, rdat;
  logic [13:0]          pm_data;
  logic [7:0]           dm_rdata;
  logic [3:0]           phase;
  cfs_pkg::cfs_pm_req_s pm_req;
  cfs_pkg::cfs_dm_req_s dm_req;
  logic [9:0]           fetches [$];
  int                   mismatches, n_compared;
  localparam logic [9:0] exp_f [0:14] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h004,
    10'h005, 10'h006, 10'h007, 10'h008, 10'h009, 10'h020, 10'h021, 10'h022, 10'h009, 10'h00a};
  localparam logic [7:0] alu_exp [0:15] = '{8'hcb, 8'hcb, 8'h61, 8'h60, 8'h14, 8'hb7,
    8'ha3, 8'hca, 8'h96, 8'h9a, 8'h1a, 8'h6a, 8'h6a, 8'h36, 8'h34, 8'h35};
  cfs_core i_dut (.clk(clk), .sys_rst(sys_rst), .pm_data(pm_data), .dm_rdata(dm_rdata),
    .irq_event(irq_event), .pm_req(pm_req), .dm_req(dm_req), .instr_phase_clocks(phase),
    .irq_ack(irq_ack), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  cfs_mem_model i_mem (.clk(clk), .pm_req(pm_req), .dm_req(dm_req),
    .instr_phase_clocks(phase), .pm_data(pm_data), .dm_rdata(dm_rdata));
  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (pm_req.rd === 1'b1)
      fetches.push_back(pm_req.addr);
    if (irq_ack === 1'b1)
      acked <= 1'b1;
    // A return to address one after the acknowledge means no entry was lost.
    if (acked && pm_req.rd === 1'b1 && pm_req.addr === 10'h001)
      old_seen <= 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Only the watchdog ends a wait that never gets its answer.
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wait_fetch(input logic [9:0] a);
    hit = 1'b0;
    for (int i = 0; i < 600 && !hit; i++) begin
      @(posedge clk);
      hit = (pm_req.rd === 1'b1) && (pm_req.addr === a);
    end
  endtask
  task automatic ld(input logic [9:0] a, input logic [13:0] w);
    i_mem.pm_mem[a] = w;
  endtask
  task automatic restart;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    fetches.delete();
    acked = 1'b0;
    old_seen = 1'b0;
  endtask
  task automatic summarize;
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    summarize();
  end
  initial begin
    sys_rst = 1'b1;
    irq_event = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    mismatches = 0;
    n_compared = 0;
    i_mem.wipe();
    restart();
    bus(1'b0, 5'h08, 32'h0);
    check(rdat, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    check(rdat, 32'h0);
    bus(1'b1, 5'h0c, 32'hff);
    bus(1'b0, 5'h0c, 32'h0);
    check(rdat, 32'h0);
    check({22'h0, fetches[0]}, 32'h0);
    $display("test reset done");
    // Arithmetic, rotation through carry, skip, call and return.
    ld(10'h000, 14'h1f3c);
    ld(10'h001, 14'h10c5);
    ld(10'h002, 14'h3810);
    ld(10'h003, 14'h0c90);
    ld(10'h004, 14'h0610);
    ld(10'h005, 14'h0a10);
    ld(10'h006, 14'h3411);
    ld(10'h007, 14'h1f77);
    ld(10'h008, 14'h2820);
    ld(10'h009, 14'h3812);
    ld(10'h00a, 14'h200a);
    ld(10'h020, 14'h1005);
    ld(10'h021, 14'h3000);
    restart();
    wait_fetch(10'h00b);
    check({31'h0, hit}, 32'h1);
    for (int i = 0; i < 15; i++) check({22'h0, fetches[i]}, {22'h0, exp_f[i]});
    check({24'h0, i_mem.dm_mem[7'h10]}, 32'h3);
    check({24'h0, i_mem.dm_mem[7'h12]}, 32'h6);
    bus(1'b0, 5'h0c, 32'h0);
    check(rdat, 32'h6);
    $display("test program flow done");
    // Every ALU function with the literal form, from clear flags.
    for (int f = 0; f < 16; f++) begin
      i_mem.wipe();
      ld(10'h000, 14'h1f96);
      ld(10'h001, {2'h1, 4'(f), 8'h35});
      ld(10'h002, 14'h2002);
      restart();
      wait_fetch(10'h003);
      bus(1'b0, 5'h0c, 32'h0);
      check(rdat, {24'h0, alu_exp[f]});
    end
    $display("test alu done");
    // A low byte write keeps the page of the running code.
    i_mem.wipe();
    ld(10'h000, 14'h2105);
    ld(10'h105, 14'h2105);
    ld(10'h130, 14'h2130);
    restart();
    wait_fetch(10'h106);
    bus(1'b1, 5'h00, 32'h30);
    wait_fetch(10'h131);
    check({31'h0, hit}, 32'h1);
    $display("test low byte done");
    // Interrupt held off while full, then overflow by a call.
    i_mem.wipe();
    ld(10'h000, 14'h2810);
    ld(10'h001, 14'h2001);
    ld(10'h010, 14'h2820);
    ld(10'h011, 14'h2011);
    ld(10'h020, 14'h3640);
    ld(10'h021, 14'h2020);
    ld(10'h022, 14'h3000);
    ld(10'h004, 14'h2830);
    ld(10'h005, 14'h3000);
    ld(10'h030, 14'h3000);
    restart();
    bus(1'b1, 5'h04, 32'h1);
    wait_fetch(10'h021);
    @(posedge clk) irq_event <= 1'b1;
    @(posedge clk) irq_event <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1'b0, 5'h08, 32'h0);
    check(rdat & 32'h70, 32'h60);
    check({31'h0, acked}, 32'h0);
    i_mem.dm_mem[7'h40] = 8'h01;
    // The interrupt cycle itself fetches 0x012; wait for the handler first.
    wait_fetch(10'h030);
    wait_fetch(10'h012);
    check({31'h0, hit & acked}, 32'h1);
    check({31'h0, old_seen}, 32'h0);
    bus(1'b0, 5'h08, 32'h0);
    check(rdat & 32'h70, 32'h0);
    $display("test stack done");
    summarize();
  end
endmodule // testbench
